//--- mgmt_station_model.sv
// station management model: register write and read frames
// assumes strobes are sampled on the rising edge of sys_clk
`timescale 1ns/100ps
module mgmt_station_model #(
    parameter int BUSY_CYC = 6
) (
    // clock
    input wire logic sys_clk,
    // register access
    output logic reg_wr,
    output logic reg_rd,
    output logic reg_rd_busy,
    output logic [4:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    logic [15:0] last_rdata;

    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_rd_busy = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
    end

    // callers enter just after a rising edge
    task automatic wr(input logic [4:0] a, input logic [15:0] dat);
        reg_addr = a;
        reg_wdata = dat;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
        // released bus shows no stale value
        reg_wdata = ~dat;
        reg_addr = ~a;
        // idle edge so a following call never rewrites the strobe in this step
        @(posedge sys_clk);
        #1;
    endtask : wr

    // busy stays up while the frame shifts the word out
    task automatic rd(input logic [4:0] a, output logic [15:0] dat);
        reg_addr = a;
        reg_rd = 1'b1;
        reg_rd_busy = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b0;
        dat = reg_rdata;
        repeat (BUSY_CYC) @(posedge sys_clk);
        #1;
        last_rdata = reg_rdata;
        reg_rd_busy = 1'b0;
        reg_addr = ~a;
        @(posedge sys_clk);
        #1;
    endtask : rd
endmodule : mgmt_station_model

//--- phy_mgmt_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes a management frame engine presents decoded register accesses
`ifndef PHY_MGMT_DEFS_SVH
`define PHY_MGMT_DEFS_SVH

`define OFS_SPEC_STATUS 5'h11
`define OFS_EVENT_ENABLE 5'h12
`define OFS_EVENT_FLAGS 5'h13
`define OFS_DOWNGRADE_CTL 5'h14
`define OFS_RX_ERR_COUNT 5'h15
`define OFS_EXT_ADDRESS 5'h1e
`define OFS_EXT_DATA 5'h1f
`define EXT_LINK_OPTIONS 8'h00
`define EXT_MANUAL_EEE 8'h04

`define EVENT_ENABLE_MASK 16'hfc63
`define EVT_NEG_ERROR 15
`define EVT_SPEED 14
`define EVT_DUPLEX 13
`define EVT_PAGE 12
`define EVT_LINK_DOWN 11
`define EVT_LINK_UP 10
`define EVT_WOL 6
`define EVT_DOWNGRADE 5
`define EVT_POLARITY 1
`define EVT_JABBER 0

`define DGC_WRITE_MASK 16'h0f3e
`define DGC_RESET 16'h082c
`define DGC_READ_LATCH 11
`define DGC_RESTART 10
`define DGC_REVERSE 9
`define DGC_NO_GIGA 8
`define DGC_DOWNGRADE_EN 5
`define DGC_RETRY_LSB 2
`define DGC_TIMER_SKIP 1

`define LINKOPT_WRITE_MASK 16'h00e1
`define LINKOPT_RESET 16'h0081
`define LINKOPT_DEGLITCH 7
`define LINKOPT_JUMBO 5
`define LINKOPT_ROLE 0
`define EEE_WRITE_MASK 16'he000
`define EEE_RESET 16'h8000
`define EEE_NP_TX 15
`define EEE_NP_RX 14
`define EEE_FORCE 13

`define STS_MDIX 6
`define RX_ERR_MAX 16'hffff
`define STABLE_TIME_MS 2500
`define CLK_MHZ 250
`define STABLE_CYCLES (`STABLE_TIME_MS * 1000 * `CLK_MHZ)
`endif

//--- phy_mgmt_pkg.sv
// types shared by the management register block
// assumes phy_mgmt_defs.svh supplies the numeric constants
package phy_mgmt_pkg;
    typedef struct packed {
        logic link_up;
        logic resolved;
        logic forced;
        logic [1:0] speed;
        logic full_duplex;
        logic mdix;
        logic pause_tx;
        logic pause_rx;
        logic pol_reversed;
        logic jabber;
        logic page_rx;
        logic neg_error;
        logic wol_frame;
        logic downgraded;
    } line_state_t;

    typedef struct packed {
        logic read_latch;
        logic restart_neg;
        logic reverse_order;
        logic no_giga;
        logic downgrade_en;
        logic [2:0] retry_limit;
        logic timer_skip;
        logic deglitch;
        logic jumbo;
        logic fixed_role_select;
        logic eee_np_tx;
        logic eee_np_rx;
        logic eee_force;
    } ctrl_out_t;

    typedef enum logic [1:0] {DG_IDLE, DG_WAIT_LINK, DG_HOLD} dg_state_t;
endpackage : phy_mgmt_pkg

//--- phy_status_irq_regs.sv
// management register bank: status, events, downgrade, rx errors, extended window
// assumes reg access strobes from the management frame engine on sys_clk
// How it works
// [R1] crossover bit reports mdix once resolved
// [R2] pause bits zero when speed forced
// [R3] polarity and jabber bits follow live state
// [R4] enables gate the interrupt, not the flags, all reset zero
// [R5] link down and link up events
// [R6] speed, duplex and page events
// [R7] wol, downgrade, polarity, jabber events
// [R8] negotiation error sets its flag
// [R9] read latch holds data during reads
// [R10] writing restart bit restarts negotiation
// [R11] reverse bit gives low speed priority
// [R12] suppress bit hides gigabit ability
// [R13] downgrade enable applies after soft reset
// [R14] attempts equal retry field plus two
// [R15] short links count as failed attempts
// [R16] saturating rx error counter on rx_er rise
// [R17] extended address selects window target
// [R18] extended data reads and writes target
// [R19] deglitch enable resets to one
// [R20] jumbo enable resets to zero
// [R21] fixed role bit decides forced role
// [R22] eee next page and ability overrides
// [R23] interrupt follows enabled pending events
// [R24] flags clear on read, set wins
`timescale 1ns/100ps
`include "phy_mgmt_defs.svh"

module phy_status_irq_regs #(
    parameter int STABLE_CYCLES = `STABLE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic soft_reset,
    // register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_rd_busy,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // line state
    input wire phy_mgmt_pkg::line_state_t line,
    input wire logic rx_er,
    input wire logic rx_dv,
    // controls and status
    output phy_mgmt_pkg::ctrl_out_t ctrl,
    output logic neg_attempts_exhausted,
    output logic irq
);
    logic [15:0] enable_r, flags_r, dgc_r, dgc_live_r, err_r;
    logic [7:0] xaddr_r;
    logic [15:0] linkopt_r, eee_r;
    logic [15:0] rdata_nxt, rdata_r, status_w, flags_set, ext_rd;
    logic link_q, spd_q, dpx_q, pol_q, jab_q, rxer_q, page_q;
    logic [1:0] speed_q;
    logic [2:0] attempt_r;
    logic [31:0] stable_cnt_r;
    logic restart_r, exhausted_r, irq_r;
    phy_mgmt_pkg::dg_state_t dg_r;

    function automatic logic [15:0] masked_wr(input logic [15:0] old, input logic [15:0] d,
                                              input logic [15:0] m);
        masked_wr = (old & ~m) | (d & m);
    endfunction : masked_wr

    wire wr_enable = reg_wr && reg_addr == `OFS_EVENT_ENABLE;
    wire rd_flags = reg_rd && reg_addr == `OFS_EVENT_FLAGS;
    wire wr_dgc = reg_wr && reg_addr == `OFS_DOWNGRADE_CTL;
    wire wr_xaddr = reg_wr && reg_addr == `OFS_EXT_ADDRESS;
    wire wr_xdata = reg_wr && reg_addr == `OFS_EXT_DATA;
    wire sel_linkopt = xaddr_r == `EXT_LINK_OPTIONS; // [R17]
    wire sel_eee = xaddr_r == `EXT_MANUAL_EEE;
    wire pause_ok = line.resolved && !line.forced; // [R2]

    // [R1] [R2] [R3]
    assign status_w = {line.speed, line.full_duplex, line.page_rx, line.resolved,
                       line.link_up, 3'h0, line.resolved & line.mdix, line.downgraded,
                       1'b0, pause_ok & line.pause_tx, pause_ok & line.pause_rx,
                       line.pol_reversed, line.jabber};

    // [R5] [R6] [R7] [R8]
    assign flags_set = {line.neg_error, speed_q != line.speed, dpx_q != line.full_duplex,
                        line.page_rx & ~page_q, link_q & ~line.link_up,
                        ~link_q & line.link_up, 3'h0, line.wol_frame,
                        line.downgraded & ~spd_q, 3'h0, line.pol_reversed & ~pol_q,
                        line.jabber & ~jab_q};

    assign ext_rd = sel_linkopt ? linkopt_r : (sel_eee ? eee_r : 16'h0000); // [R18]

    always_comb begin
        case (reg_addr)
            `OFS_SPEC_STATUS: rdata_nxt = status_w;
            `OFS_EVENT_ENABLE: rdata_nxt = enable_r;
            `OFS_EVENT_FLAGS: rdata_nxt = flags_r;
            `OFS_DOWNGRADE_CTL: rdata_nxt = dgc_r;
            `OFS_RX_ERR_COUNT: rdata_nxt = err_r;
            `OFS_EXT_ADDRESS: rdata_nxt = {8'h00, xaddr_r};
            `OFS_EXT_DATA: rdata_nxt = ext_rd;
            default: rdata_nxt = 16'h0000;
        endcase
    end

    // history of line state for edge detection; inputs share sys_clk
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_q <= 1'b0;
            speed_q <= 2'h0;
            dpx_q <= 1'b0;
            pol_q <= 1'b0;
            jab_q <= 1'b0;
            spd_q <= 1'b0;
            page_q <= 1'b0;
            rxer_q <= 1'b0;
        end else begin
            link_q <= line.link_up;
            speed_q <= line.speed;
            dpx_q <= line.full_duplex;
            pol_q <= line.pol_reversed;
            jab_q <= line.jabber;
            spd_q <= line.downgraded;
            page_q <= line.page_rx;
            rxer_q <= rx_er;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_r <= 16'h0000; // [R4]
            flags_r <= 16'h0000;
        end else if (soft_reset) begin
            enable_r <= 16'h0000;
            flags_r <= 16'h0000;
        end else begin
            if (wr_enable)
                enable_r <= reg_wdata & `EVENT_ENABLE_MASK;
            // set wins over the clear-on-read
            flags_r <= ((rd_flags ? 16'h0000 : flags_r) | flags_set)
                       & `EVENT_ENABLE_MASK; // [R24]
        end
    end

    // [R23]
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            irq_r <= 1'b0;
        else
            irq_r <= |(flags_r & enable_r);
    end

    // [R9] held read data stays frozen while the engine shifts it out
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            rdata_r <= 16'h0000;
        else if (reg_rd || !(dgc_r[`DGC_READ_LATCH] && reg_rd_busy))
            rdata_r <= rdata_nxt;
    end

    // [R13] [R14] [R15] live copy refreshed only by soft reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dgc_r <= `DGC_RESET;
            dgc_live_r <= `DGC_RESET;
            restart_r <= 1'b0;
        end else begin
            restart_r <= wr_dgc && reg_wdata[`DGC_RESTART]; // [R10]
            if (soft_reset)
                dgc_live_r <= dgc_r;
            if (wr_dgc)
                dgc_r <= masked_wr(dgc_r, reg_wdata, `DGC_WRITE_MASK);
        end
    end

    // [R16]
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            err_r <= 16'h0000;
        else if (rx_er && !rxer_q && rx_dv && err_r != `RX_ERR_MAX)
            err_r <= err_r + 16'h0001;
    end

    // [R17] [R18] [R19] [R20] [R21] [R22]
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            xaddr_r <= 8'h00;
            linkopt_r <= `LINKOPT_RESET;
            eee_r <= `EEE_RESET;
        end else begin
            if (wr_xaddr)
                xaddr_r <= reg_wdata[7:0];
            if (wr_xdata && sel_linkopt)
                linkopt_r <= masked_wr(linkopt_r, reg_wdata, `LINKOPT_WRITE_MASK);
            if (soft_reset)
                eee_r <= `EEE_RESET;
            else if (wr_xdata && sel_eee)
                eee_r <= masked_wr(eee_r, reg_wdata, `EEE_WRITE_MASK);
        end
    end

    // [R14] [R15] attempt counter; links shorter than the stability time fail
    wire [2:0] limit_w = dgc_live_r[`DGC_RETRY_LSB +: 3];
    wire [3:0] attempts_w = {1'b0, limit_w} + 4'h2;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dg_r <= phy_mgmt_pkg::DG_WAIT_LINK;
            attempt_r <= 3'h0;
            stable_cnt_r <= 32'h0;
            exhausted_r <= 1'b0;
        end else if (soft_reset || restart_r || !dgc_live_r[`DGC_DOWNGRADE_EN]) begin
            dg_r <= phy_mgmt_pkg::DG_WAIT_LINK;
            attempt_r <= 3'h0;
            stable_cnt_r <= 32'h0;
            exhausted_r <= 1'b0;
        end else begin
            case (dg_r)
                phy_mgmt_pkg::DG_WAIT_LINK: begin
                    if (line.link_up && !link_q) begin
                        dg_r <= phy_mgmt_pkg::DG_HOLD;
                        stable_cnt_r <= 32'h0;
                    end
                end
                phy_mgmt_pkg::DG_HOLD: begin
                    if (!line.link_up && !dgc_live_r[`DGC_TIMER_SKIP]) begin
                        dg_r <= phy_mgmt_pkg::DG_WAIT_LINK;
                        if ({1'b0, attempt_r} + 4'h1 >= attempts_w)
                            exhausted_r <= 1'b1;
                        else
                            attempt_r <= attempt_r + 3'h1;
                    end else if (stable_cnt_r == 32'(STABLE_CYCLES - 1)
                                 || dgc_live_r[`DGC_TIMER_SKIP]) begin
                        dg_r <= phy_mgmt_pkg::DG_IDLE;
                        attempt_r <= 3'h0;
                    end else begin
                        stable_cnt_r <= stable_cnt_r + 32'h1;
                    end
                end
                phy_mgmt_pkg::DG_IDLE: begin
                    if (!line.link_up)
                        dg_r <= phy_mgmt_pkg::DG_WAIT_LINK;
                end
                default: dg_r <= phy_mgmt_pkg::DG_WAIT_LINK;
            endcase
        end
    end

    // [R11] [R12] [R19] [R20] [R21] [R22]
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= '0;
        end else begin
            ctrl.read_latch <= dgc_r[`DGC_READ_LATCH];
            ctrl.restart_neg <= restart_r;
            ctrl.reverse_order <= dgc_r[`DGC_REVERSE];
            ctrl.no_giga <= dgc_r[`DGC_NO_GIGA];
            ctrl.downgrade_en <= dgc_live_r[`DGC_DOWNGRADE_EN];
            ctrl.retry_limit <= limit_w;
            ctrl.timer_skip <= dgc_live_r[`DGC_TIMER_SKIP];
            ctrl.deglitch <= linkopt_r[`LINKOPT_DEGLITCH];
            ctrl.jumbo <= linkopt_r[`LINKOPT_JUMBO];
            ctrl.fixed_role_select <= linkopt_r[`LINKOPT_ROLE];
            ctrl.eee_np_tx <= eee_r[`EEE_NP_TX];
            ctrl.eee_np_rx <= eee_r[`EEE_NP_RX];
            ctrl.eee_force <= eee_r[`EEE_FORCE];
        end
    end

    assign reg_rdata = rdata_r;
    assign irq = irq_r;
    assign neg_attempts_exhausted = exhausted_r;

    property p_link_down_flag;
        @(posedge sys_clk) disable iff (!rst_b)
        (!soft_reset && link_q && !line.link_up) |=> flags_r[`EVT_LINK_DOWN];
    endproperty
    a_link_down_flag: assert property (p_link_down_flag) else $error("link down missed"); // [R5]

    property p_link_up_flag;
        @(posedge sys_clk) disable iff (!rst_b)
        (!soft_reset && !link_q && line.link_up) |=> flags_r[`EVT_LINK_UP];
    endproperty
    a_link_up_flag: assert property (p_link_up_flag) else $error("link up missed"); // [R5]

    property p_irq_follows;
        @(posedge sys_clk) disable iff (!rst_b)
        ##1 irq == $past(|(flags_r & enable_r));
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch"); // [R23]

    property p_flag_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        (rd_flags && flags_set == 16'h0) |=> flags_r == 16'h0;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared"); // [R24]

    property p_err_sat;
        @(posedge sys_clk) disable iff (!rst_b)
        err_r == `RX_ERR_MAX |=> err_r == `RX_ERR_MAX;
    endproperty
    a_err_sat: assert property (p_err_sat) else $error("error counter wrapped"); // [R16]

    property p_err_inc;
        @(posedge sys_clk) disable iff (!rst_b)
        (rx_er && !rxer_q && rx_dv && err_r != `RX_ERR_MAX) |=> err_r == $past(err_r) + 16'h1;
    endproperty
    a_err_inc: assert property (p_err_inc) else $error("error count missed"); // [R16]

    property p_pause_forced;
        @(posedge sys_clk) disable iff (!rst_b)
        line.forced |-> status_w[3:2] == 2'b00;
    endproperty
    a_pause_forced: assert property (p_pause_forced) else $error("pause in forced mode"); // [R2]

    property p_restart;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr_dgc && reg_wdata[`DGC_RESTART]) |=> ##1 ctrl.restart_neg;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not issued"); // [R10]

    property p_dg_hold_soft;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr_dgc && !soft_reset) |=> dgc_live_r == $past(dgc_live_r);
    endproperty
    a_dg_hold_soft: assert property (p_dg_hold_soft) else $error("downgrade took early"); // [R13]

    property p_speed_flag;
        @(posedge sys_clk) disable iff (!rst_b)
        (!soft_reset && speed_q != line.speed) |=> flags_r[`EVT_SPEED];
    endproperty
    a_speed_flag: assert property (p_speed_flag) else $error("speed event missed"); // [R6]

    property p_pol_flag;
        @(posedge sys_clk) disable iff (!rst_b)
        (!soft_reset && line.pol_reversed && !pol_q) |=> flags_r[`EVT_POLARITY];
    endproperty
    a_pol_flag: assert property (p_pol_flag) else $error("polarity event missed"); // [R7]

    property p_enable_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr_enable && !soft_reset) |=> enable_r == ($past(reg_wdata) & `EVENT_ENABLE_MASK);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost"); // [R4]

    property p_read_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        (dgc_r[`DGC_READ_LATCH] && reg_rd_busy && !reg_rd) |=> $stable(reg_rdata);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data moved"); // [R9]

    property p_xover_valid;
        @(posedge sys_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == `OFS_SPEC_STATUS && !line.resolved) |=> !reg_rdata[`STS_MDIX];
    endproperty
    a_xover_valid: assert property (p_xover_valid) else $error("crossover before resolve"); // [R1]

    property p_ext_read;
        @(posedge sys_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == `OFS_EXT_DATA && sel_eee) |=> reg_rdata == $past(eee_r);
    endproperty
    a_ext_read: assert property (p_ext_read) else $error("window read wrong"); // [R18]

    property p_exhaust_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        (soft_reset || restart_r) |=> !exhausted_r;
    endproperty
    a_exhaust_clear: assert property (p_exhaust_clear) else $error("retry budget kept"); // [R14]

    c_flag_irq: cover property (@(posedge sys_clk) disable iff (!rst_b) irq ##1 rd_flags);
    c_restart: cover property (@(posedge sys_clk) disable iff (!rst_b) ctrl.restart_neg);
    c_latch_hold: cover property (@(posedge sys_clk) disable iff (!rst_b)
        reg_rd ##1 (reg_rd_busy && dgc_r[`DGC_READ_LATCH]));
    c_exhaust: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(exhausted_r));
    c_err_sat: cover property (@(posedge sys_clk) disable iff (!rst_b) err_r == `RX_ERR_MAX);
endmodule : phy_status_irq_regs

//--- testbench.sv
// self-checking bench for the management register bank
// assumes the station model above and the design's defines header
`timescale 1ns/100ps
`include "phy_mgmt_defs.svh"
module testbench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic soft_reset = 1'b0;
    logic reg_wr, reg_rd, reg_rd_busy, seen;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    phy_mgmt_pkg::line_state_t line = '0;
    phy_mgmt_pkg::ctrl_out_t ctrl, ec;
    logic rx_er = 1'b0;
    logic rx_dv = 1'b0;
    logic err_run = 1'b0;
    logic neg_attempts_exhausted, irq;
    int n_mismatch = 0;
    int num_checks = 0;
    int evt_bit [10] = '{10, 11, 14, 13, 12, 15, 6, 5, 1, 0};

    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (err_run) begin
        #1;
        rx_er = ~rx_er;
    end

    // short stability count keeps the run brief
    phy_status_irq_regs #(.STABLE_CYCLES(20)) phy_status_irq_regs_inst (.sys_clk(sys_clk),
        .rst_b(rst_b), .soft_reset(soft_reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rd_busy(reg_rd_busy), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .line(line), .rx_er(rx_er), .rx_dv(rx_dv), .ctrl(ctrl),
        .neg_attempts_exhausted(neg_attempts_exhausted), .irq(irq));
    mgmt_station_model mgmt_station_model_inst (.sys_clk(sys_clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rd_busy(reg_rd_busy), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [15:0] dat);
        mgmt_station_model_inst.wr(a, dat);
    endtask : wr

    task automatic rchk(input string nm, input logic [4:0] a, input logic [15:0] m,
        input logic [15:0] e);
        mgmt_station_model_inst.rd(a, d);
        chk(nm, e, d & m);
    endtask : rchk

    task automatic raise_evt(input int k);
        case (k)
            0: line.link_up = 1'b1;
            1: line.link_up = 1'b0;
            2: line.speed = 2'h2;
            3: line.full_duplex = 1'b1;
            4: line.page_rx = 1'b1;
            5: line.neg_error = 1'b1;
            6: line.wol_frame = 1'b1;
            7: line.downgraded = 1'b1;
            8: line.pol_reversed = 1'b1;
            default: line.jabber = 1'b1;
        endcase
        tick(1);
        line.page_rx = 1'b0;
        line.neg_error = 1'b0;
        line.wol_frame = 1'b0;
        line.downgraded = 1'b0;
        line.pol_reversed = 1'b0;
        line.jabber = 1'b0;
    endtask : raise_evt

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        $display("Error timeout expected done seen hang");
        print_verdict();
    end

    initial begin
        tick(20);
        rst_b = 1'b1;
        tick(1);
        ec = '0;
        ec.read_latch = 1'b1;
        ec.downgrade_en = 1'b1;
        ec.retry_limit = 3'h3;
        ec.deglitch = 1'b1;
        ec.fixed_role_select = 1'b1;
        ec.eee_np_tx = 1'b1;
        chk("ctrl_reset", {1'b0, ec}, {1'b0, ctrl});
        rchk("enable_reset", `OFS_EVENT_ENABLE, 16'hffff, 16'h0000);
        rchk("downgrade_reset", `OFS_DOWNGRADE_CTL, 16'hffff, 16'h082c);
        rchk("err_reset", `OFS_RX_ERR_COUNT, 16'hffff, 16'h0000);
        wr(`OFS_EXT_ADDRESS, 16'h0000);
        rchk("linkopt_reset", `OFS_EXT_DATA, 16'hffff, 16'h0081);
        wr(`OFS_EXT_ADDRESS, 16'hff04);
        rchk("eee_reset", `OFS_EXT_DATA, 16'hffff, 16'h8000);
        rchk("ext_addr", `OFS_EXT_ADDRESS, 16'hffff, 16'h0004);
        wr(`OFS_EXT_DATA, 16'h6000);
        rchk("eee_write", `OFS_EXT_DATA, 16'hffff, 16'h6000);
        wr(`OFS_EXT_ADDRESS, 16'h0000);
        wr(`OFS_EXT_DATA, 16'hffff);
        rchk("linkopt_write", `OFS_EXT_DATA, 16'hffff, 16'h00e1);
        wr(`OFS_EXT_ADDRESS, 16'h0005);
        rchk("ext_unused", `OFS_EXT_DATA, 16'hffff, 16'h0000);
        wr(5'h05, 16'hffff);
        rchk("unmapped", 5'h05, 16'hffff, 16'h0000);
        ec.jumbo = 1'b1;
        ec.eee_np_tx = 1'b0;
        ec.eee_np_rx = 1'b1;
        ec.eee_force = 1'b1;
        chk("ctrl_ext", {1'b0, ec}, {1'b0, ctrl});
        $display("test reset and window done");

        line = '0;
        line.resolved = 1'b1;
        line.mdix = 1'b1;
        line.pause_tx = 1'b1;
        line.pause_rx = 1'b1;
        line.pol_reversed = 1'b1;
        line.jabber = 1'b1;
        tick(2);
        rchk("status_neg", `OFS_SPEC_STATUS, 16'h004f, 16'h004f);
        line.forced = 1'b1;
        line.pol_reversed = 1'b0;
        line.jabber = 1'b0;
        tick(2);
        rchk("status_forced", `OFS_SPEC_STATUS, 16'h004f, 16'h0040);
        line = '0;
        line.mdix = 1'b1;
        rchk("status_unresolved", `OFS_SPEC_STATUS, 16'h0840, 16'h0000);
        line = '0;
        $display("test status done");

        wr(`OFS_EVENT_ENABLE, 16'hffff);
        rchk("enable_rw", `OFS_EVENT_ENABLE, 16'hffff, 16'hfc63);
        for (int k = 0; k < 10; k++) begin
            mgmt_station_model_inst.rd(`OFS_EVENT_FLAGS, d);
            raise_evt(k);
            tick(2);
            chk("irq_set", 16'h0001, {15'h0, irq});
            rchk("flag", `OFS_EVENT_FLAGS, 16'h1 << evt_bit[k], 16'h1 << evt_bit[k]);
            rchk("flag_clr", `OFS_EVENT_FLAGS, 16'h1 << evt_bit[k], 16'h0000);
            tick(2);
            chk("irq_clr", 16'h0000, {15'h0, irq});
        end
        wr(`OFS_EVENT_ENABLE, 16'h0400);
        line.full_duplex = 1'b0;
        tick(3);
        chk("irq_masked", 16'h0000, {15'h0, irq});
        rchk("flag_masked", `OFS_EVENT_FLAGS, 16'h2000, 16'h2000);
        $display("test events done");

        // errors without valid data must not count
        err_run = 1'b1;
        tick(8);
        err_run = 1'b0;
        tick(1);
        rx_er = 1'b0;
        rchk("err_no_dv", `OFS_RX_ERR_COUNT, 16'hffff, 16'h0000);
        rx_dv = 1'b1;
        for (int i = 0; i < 3; i++) begin
            rx_er = 1'b1;
            tick(3);
            rx_er = 1'b0;
            tick(1);
        end
        rchk("err_count", `OFS_RX_ERR_COUNT, 16'hffff, 16'h0003);
        err_run = 1'b1;
        mgmt_station_model_inst.rd(`OFS_RX_ERR_COUNT, d);
        chk("latch_on", d, mgmt_station_model_inst.last_rdata);
        wr(`OFS_DOWNGRADE_CTL, 16'h002c);
        mgmt_station_model_inst.rd(`OFS_RX_ERR_COUNT, d);
        chk("latch_off", 16'h0001, {15'h0, d !== mgmt_station_model_inst.last_rdata});
        err_run = 1'b0;
        tick(1);
        rx_er = 1'b0;
        $display("test rx errors done");

        // four short links, one stable link, then five short links use up the budget
        for (int i = 0; i < 10; i++) begin
            line.link_up = 1'b1;
            tick(i == 4 ? 25 : 3);
            line.link_up = 1'b0;
            tick(2);
            chk("exhausted", {15'h0, i == 9}, {15'h0, neg_attempts_exhausted});
        end
        wr(`OFS_DOWNGRADE_CTL, 16'hffd7);
        seen = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (ctrl.restart_neg === 1'b1)
                seen = 1'b1;
            tick(1);
        end
        chk("restart", 16'h0001, {15'h0, seen});
        chk("exhaust_clr", 16'h0000, {15'h0, neg_attempts_exhausted});
        rchk("downgrade_rw", `OFS_DOWNGRADE_CTL, 16'hfbff, 16'h0b16);
        ec.reverse_order = 1'b1;
        ec.no_giga = 1'b1;
        chk("ctrl_before", {1'b0, ec}, {1'b0, ctrl});
        soft_reset = 1'b1;
        tick(1);
        soft_reset = 1'b0;
        tick(2);
        ec.downgrade_en = 1'b0;
        ec.retry_limit = 3'h5;
        ec.timer_skip = 1'b1;
        ec.eee_np_tx = 1'b1;
        ec.eee_np_rx = 1'b0;
        ec.eee_force = 1'b0;
        chk("ctrl_after", {1'b0, ec}, {1'b0, ctrl});
        rchk("enable_soft", `OFS_EVENT_ENABLE, 16'hffff, 16'h0000);
        $display("test downgrade done");
        print_verdict();
    end
endmodule : testbench
